//--- core/modbus_slave_decoder.sv
`timescale 1ns/1ps
// Summary of operation
// - Only RTU frames are accepted: silence-delimited, CRC-checked.
// - Requests are serviced by hardware alone, no program involvement.
// - Code 01 reads a run of output, relay, stage, timer or counter contacts.
// - Code 02 reads a run of physical inputs or system relay bits.
// - Code 05 forces one coil on or off, slave mode only.
// - Code 15 forces a run of coils on or off.
// - Codes 03 and 04 read one or more consecutive 16-bit words.
// - Code 06 writes one data word, slave mode only.
// - Code 16 writes a run of data words.
// - Bit spaces and word spaces use different address equations.
// - Bit address is index plus base: 2048 I/O, 3072 relays, 6144 timers.
// - Stage bits at coils 5120 to 6143; counter contacts from 6400.
// - Word register address is the word index plus base: 0 timers, 512 counters, 1024 data.
// - Timer values are input registers 0 to 255.
// - Counter values are input registers 512 to 767.
// - User data words are holding registers 1024 to 2047.
// - Port is slave after power-up and again after any master activity.
// - Bit rate selectable among eight rates, common to all nodes.
// - Characters take one or two stop bits and none, even or odd parity.
module modbus_slave_decoder
    import modbus_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         rx_pin,
    input  wire logic [2:0]   baud_sel,
    input  wire logic [1:0]   parity_mode,
    input  wire logic         two_stop,
    input  wire logic [7:0]   station_addr,
    input  wire logic         master_busy,
    output logic              mem_req,
    output logic              mem_we,
    output modbus_pkg::space_t mem_space,
    output logic [10:0]       mem_index,
    output logic              mem_wbit,
    output logic [15:0]       mem_wword,
    input  wire logic [15:0]  mem_rdata,
    output logic              resp_valid,
    output logic [15:0]       resp_data,
    output logic              resp_done,
    output logic [7:0]        resp_func,
    output logic [7:0]        resp_exc
);
    import modbus_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef enum logic [4:0] {
        ST_RX    = 5'h01,
        ST_CHK   = 5'h02,
        ST_RUN   = 5'h04,
        ST_DRAIN = 5'h08,
        ST_FIN   = 5'h10
    } st_t;

    typedef struct packed {
        st_t                     st;
        logic [FRAME_BYTES-1:0][7:0] buf_b;
        logic [6:0]              cnt;
        logic [15:0]             crc;
        logic                    bad;
        logic [9:0]              gap;
        logic [7:0]              fc;
        logic [15:0]             addr;
        logic [10:0]             qty;
        logic [10:0]             i;
        logic                    req;
        logic                    we;
        space_t                  sp;
        logic [10:0]             idx;
        logic                    wbit;
        logic [15:0]             wword;
        logic                    pend;
        logic                    rv;
        logic [15:0]             rdata;
        logic                    done;
        logic [7:0]              exc;
    } core_t;

    core_t c_r, c_nxt;

    logic       samp_tick;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       byte_err;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic kind_t kind_of(input logic [7:0] fc);
        if (fc == FC_RD_INPUTS) return KIND_INPUT;
        if (fc == FC_RD_COILS || fc == FC_WR_COIL || fc == FC_WR_COILS) return KIND_COIL;
        return KIND_WORD;
    endfunction

    function automatic logic is_write(input logic [7:0] fc);
        return fc == FC_WR_COIL || fc == FC_WR_REG || fc == FC_WR_COILS || fc == FC_WR_REGS;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Character layer

    baud_gen u_baud (
        .clk       (clk),
        .reset_n   (reset_n),
        .baud_sel  (baud_sel),
        .samp_tick (samp_tick)
    );

    serial_rx u_rx (
        .clk         (clk),
        .reset_n     (reset_n),
        .samp_tick   (samp_tick),
        .rx_pin      (rx_pin),
        .parity_mode (parity_mode),
        .two_stop    (two_stop),
        .byte_valid  (byte_valid),
        .byte_data   (byte_data),
        .byte_err    (byte_err)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Request decoder

    always_comb begin
        logic [7:0]  fc;
        logic [15:0] a;
        logic [15:0] q;
        logic [7:0]  bc;
        logic [15:0] qn;
        logic [16:0] last;
        logic        supp;
        logic        len_ok;
        logic        frame_ok;
        logic [7:0]  ex;
        kind_t       k;
        map_t        m0;
        map_t        m1;
        map_t        mr;
        logic [5:0]  bi;
        logic [5:0]  wi;

        fc   = c_r.buf_b[1];
        a    = {c_r.buf_b[2], c_r.buf_b[3]};
        q    = {c_r.buf_b[4], c_r.buf_b[5]};
        bc   = c_r.buf_b[6];
        qn   = (fc == FC_WR_COIL || fc == FC_WR_REG) ? 16'h0001 : q;
        last = {1'b0, a} + {1'b0, qn} - 17'h00001;
        supp = fc == FC_RD_COILS || fc == FC_RD_INPUTS || fc == FC_RD_HOLD
            || fc == FC_RD_INREG || is_write(fc);
        len_ok = (fc == FC_WR_COILS || fc == FC_WR_REGS)
            ? ({2'b00, c_r.cnt} == 9'h009 + {1'b0, bc}) : (c_r.cnt == 7'h08);
        // Corrupt or foreign frames are dropped without any answer
        frame_ok = !c_r.bad && c_r.crc == 16'h0000 && c_r.cnt >= 7'h04
            && c_r.buf_b[0] == station_addr && (len_ok || !supp);
        k  = kind_of(fc);
        m0 = addr_map(k, a);
        m1 = addr_map(k, last[15:0]);
        mr = addr_map(kind_of(c_r.fc), c_r.addr + 16'(c_r.i));
        bi = 6'(c_r.i[10:3]) + 6'h07;
        wi = {c_r.i[4:0], 1'b0} + 6'h07;

        ex = EXC_NONE;
        if (!supp) ex = EXC_ILL_FUNC;
        else if (qn == 16'h0000) ex = EXC_ILL_VAL;
        else if (k != KIND_WORD && qn > MAX_BITS) ex = EXC_ILL_VAL;
        else if (k == KIND_WORD && qn > MAX_WORDS) ex = EXC_ILL_VAL;
        else if (fc == FC_WR_COIL && q != COIL_ON && q != 16'h0000) ex = EXC_ILL_VAL;
        else if (fc == FC_WR_COILS && {1'b0, q} + 17'h00007 != {6'h00, bc, 3'h0}
            && (({1'b0, q} + 17'h00007) >> 3) != {9'h000, bc}) ex = EXC_ILL_VAL;
        else if (fc == FC_WR_REGS && {q, 1'b0} != {9'h000, bc}) ex = EXC_ILL_VAL;
        else if (!m0.ok || !m1.ok || last[16] || m0.sp != m1.sp) ex = EXC_ILL_ADDR;
        else if (is_write(fc) && k == KIND_WORD && m0.sp != SPACE_DATA)
            ex = EXC_ILL_ADDR;

        c_nxt       = c_r;
        c_nxt.req   = 1'b0;
        c_nxt.we    = 1'b0;
        c_nxt.done  = 1'b0;
        c_nxt.pend  = c_r.req & ~c_r.we;
        c_nxt.rv    = c_r.pend;
        c_nxt.rdata = mem_rdata;
        if (samp_tick && c_r.gap != GAP_SAMP) c_nxt.gap = c_r.gap + 10'h001;

        // Free-running: no enable from software is needed
        case (c_r.st)
            ST_RX: begin
                if (byte_valid) begin
                    c_nxt.gap = 10'h000;
                    // Marks left over from idle time must not spoil the next frame
                    if (c_r.cnt == 7'h00) c_nxt.bad = 1'b0;
                    c_nxt.crc = crc_step(c_r.crc, byte_data);
                    if (c_r.cnt == 7'(FRAME_BYTES)) begin
                        c_nxt.bad = 1'b1;
                    end else begin
                        c_nxt.buf_b[c_r.cnt[5:0]] = byte_data;
                        c_nxt.cnt = c_r.cnt + 7'h01;
                    end
                    if (byte_err) c_nxt.bad = 1'b1;
                end
                // Traffic seen while acting as master is never serviced
                if (master_busy) c_nxt.bad = 1'b1;
                if (c_r.gap == GAP_SAMP && c_r.cnt != 7'h00) c_nxt.st = ST_CHK;
            end
            ST_CHK: begin
                c_nxt.cnt  = 7'h00;
                c_nxt.crc  = CRC_INIT;
                c_nxt.bad  = 1'b0;
                c_nxt.fc   = fc;
                c_nxt.addr = a;
                c_nxt.qty  = qn[10:0];
                c_nxt.i    = 11'h000;
                c_nxt.exc  = ex;
                if (!frame_ok) c_nxt.st = ST_RX;
                else if (ex != EXC_NONE) c_nxt.st = ST_FIN;
                else c_nxt.st = ST_RUN;
            end
            ST_RUN: begin
                c_nxt.req = 1'b1;
                c_nxt.we  = is_write(c_r.fc);
                c_nxt.sp  = mr.sp;
                c_nxt.idx = mr.idx;
                c_nxt.wbit = (c_r.fc == FC_WR_COIL)
                    ? ({c_r.buf_b[4], c_r.buf_b[5]} == COIL_ON)
                    : c_r.buf_b[bi][c_r.i[2:0]];
                c_nxt.wword = (c_r.fc == FC_WR_REG)
                    ? {c_r.buf_b[4], c_r.buf_b[5]}
                    : {c_r.buf_b[wi], c_r.buf_b[6'(wi + 6'h01)]};
                c_nxt.i = c_r.i + 11'h001;
                if (c_r.i == c_r.qty - 11'h001) c_nxt.st = ST_DRAIN;
            end
            // Lets the last read word come back in the same cycle as completion
            ST_DRAIN: c_nxt.st = ST_FIN;
            ST_FIN: begin
                c_nxt.done = 1'b1;
                c_nxt.st   = ST_RX;
            end
            default: c_nxt.st = ST_RX;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            c_r <= '{st: ST_RX, crc: CRC_INIT, gap: GAP_SAMP, sp: SPACE_NONE, default: '0};
        end else begin
            c_r <= c_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign mem_req    = c_r.req;
    assign mem_we     = c_r.we;
    assign mem_space  = c_r.sp;
    assign mem_index  = c_r.idx;
    assign mem_wbit   = c_r.wbit;
    assign mem_wword  = c_r.wword;
    assign resp_valid = c_r.rv;
    assign resp_data  = c_r.rdata;
    assign resp_done  = c_r.done;
    assign resp_func  = c_r.fc;
    assign resp_exc   = c_r.exc;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    read_returns_a: assert property (@(posedge clk) disable iff (!reset_n)
        mem_req && !mem_we |-> ##2 resp_valid) else $error("read data not returned");

    word_write_data_a: assert property (@(posedge clk) disable iff (!reset_n)
        mem_req && mem_we && (mem_space == SPACE_TMRV || mem_space == SPACE_CNTV
        || mem_space == SPACE_IN || mem_space == SPACE_SYSREL) |-> 1'b0)
        else $error("write reached an input-only space");

    coil_write_kind_a: assert property (@(posedge clk) disable iff (!reset_n)
        mem_req && mem_we && resp_func == FC_WR_COILS |-> mem_space inside
        {SPACE_OUT, SPACE_CREL, SPACE_STAGE, SPACE_TMRC, SPACE_CNTC})
        else $error("coil write outside coil spaces");

    exc_no_access_a: assert property (@(posedge clk) disable iff (!reset_n)
        resp_done && resp_exc != EXC_NONE |-> !$past(mem_req) && !$past(mem_req, 2))
        else $error("memory touched on exception");

    done_single_a: assert property (@(posedge clk) disable iff (!reset_n)
        resp_done |=> !resp_done ##1 !mem_req) else $error("done not a single pulse");

    timer_index_a: assert property (@(posedge clk) disable iff (!reset_n)
        mem_req && mem_space == SPACE_TMRV |-> mem_index < 11'h100)
        else $error("timer index out of range");

    counter_index_a: assert property (@(posedge clk) disable iff (!reset_n)
        mem_req && mem_space == SPACE_CNTV |-> mem_index < 11'h100)
        else $error("counter index out of range");

    master_blocks_a: assert property (@(posedge clk) disable iff (!reset_n)
        master_busy [*3] |-> !mem_req) else $error("access while acting as master");

    valid_from_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        resp_valid |-> $past(mem_req, 2) && !$past(mem_we, 2))
        else $error("read data without a read");

    index_step_a: assert property (@(posedge clk) disable iff (!reset_n)
        mem_req && $past(mem_req) |-> mem_index == $past(mem_index) + 11'h001)
        else $error("group index not ascending");

    space_held_a: assert property (@(posedge clk) disable iff (!reset_n)
        mem_req && $past(mem_req)
        |-> mem_space == $past(mem_space) && mem_we == $past(mem_we))
        else $error("group changed space");

    coil_read_kind_a: assert property (@(posedge clk) disable iff (!reset_n)
        mem_req && resp_func == FC_RD_COILS |-> !mem_we && mem_space inside
        {SPACE_OUT, SPACE_CREL, SPACE_STAGE, SPACE_TMRC, SPACE_CNTC})
        else $error("coil read outside coil spaces");

    input_read_kind_a: assert property (@(posedge clk) disable iff (!reset_n)
        mem_req && resp_func == FC_RD_INPUTS
        |-> !mem_we && mem_space inside {SPACE_IN, SPACE_SYSREL})
        else $error("input read outside input spaces");

    word_read_kind_a: assert property (@(posedge clk) disable iff (!reset_n)
        mem_req && (resp_func == FC_RD_HOLD || resp_func == FC_RD_INREG)
        |-> !mem_we && mem_space inside {SPACE_TMRV, SPACE_CNTV, SPACE_DATA})
        else $error("word read outside word spaces");

    coil_force_kind_a: assert property (@(posedge clk) disable iff (!reset_n)
        mem_req && resp_func == FC_WR_COIL |-> mem_we && mem_space inside
        {SPACE_OUT, SPACE_CREL, SPACE_STAGE, SPACE_TMRC, SPACE_CNTC})
        else $error("coil force outside coil spaces");

    reg_write_kind_a: assert property (@(posedge clk) disable iff (!reset_n)
        mem_req && (resp_func == FC_WR_REG || resp_func == FC_WR_REGS)
        |-> mem_we && mem_space == SPACE_DATA)
        else $error("word write outside user data");

    data_index_a: assert property (@(posedge clk) disable iff (!reset_n)
        mem_req && mem_space == SPACE_DATA |-> mem_index < 11'h400)
        else $error("data index out of range");

endmodule

//--- core/modbus_pkg.sv
package modbus_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and serial timing
    localparam int          CLK_HZ      = 50_000_000;
    localparam int          OVS         = 16;
    localparam int          BAUD_RATE [8] = '{300, 600, 900, 2400, 4800, 9600, 19200, 38400};
    // Frame gap: 3.5 characters of 11 bits, in sample ticks
    localparam logic [9:0]  GAP_SAMP    = 10'h270;
    localparam int          FRAME_BYTES = 64;
    localparam logic [15:0] CRC_INIT    = 16'hffff;
    localparam logic [15:0] CRC_POLY    = 16'ha001;

    localparam logic [1:0]  PAR_NONE    = 2'h0;
    localparam logic [1:0]  PAR_EVEN    = 2'h1;
    localparam logic [1:0]  PAR_ODD     = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Function and exception codes
    localparam logic [7:0]  FC_RD_COILS  = 8'h01;
    localparam logic [7:0]  FC_RD_INPUTS = 8'h02;
    localparam logic [7:0]  FC_RD_HOLD   = 8'h03;
    localparam logic [7:0]  FC_RD_INREG  = 8'h04;
    localparam logic [7:0]  FC_WR_COIL   = 8'h05;
    localparam logic [7:0]  FC_WR_REG    = 8'h06;
    localparam logic [7:0]  FC_WR_COILS  = 8'h0f;
    localparam logic [7:0]  FC_WR_REGS   = 8'h10;

    localparam logic [7:0]  EXC_NONE     = 8'h00;
    localparam logic [7:0]  EXC_ILL_FUNC = 8'h01;
    localparam logic [7:0]  EXC_ILL_ADDR = 8'h02;
    localparam logic [7:0]  EXC_ILL_VAL  = 8'h03;

    localparam logic [15:0] COIL_ON      = 16'hff00;
    localparam logic [15:0] MAX_BITS     = 16'h07d0;
    localparam logic [15:0] MAX_WORDS    = 16'h007d;

    ////////////////////////////////////////////////////////////////////////////
    // Address map
    localparam logic [15:0] LIM_TMRV    = 16'h0100;
    localparam logic [15:0] BASE_CNTV   = 16'h0200;
    localparam logic [15:0] LIM_CNTV    = 16'h0300;
    localparam logic [15:0] BASE_DATA   = 16'h0400;
    localparam logic [15:0] BASE_IO     = 16'h0800;
    localparam logic [15:0] BASE_RELAY  = 16'h0c00;
    localparam logic [15:0] LIM_SYSREL  = 16'h0e00;
    localparam logic [15:0] BASE_STAGE  = 16'h1400;
    localparam logic [15:0] BASE_TMRC   = 16'h1800;
    localparam logic [15:0] BASE_CNTC   = 16'h1900;
    localparam logic [15:0] LIM_CNTC    = 16'h1a00;

    typedef enum logic [3:0] {
        SPACE_NONE, SPACE_IN, SPACE_SYSREL, SPACE_OUT, SPACE_CREL, SPACE_STAGE,
        SPACE_TMRC, SPACE_CNTC, SPACE_TMRV, SPACE_CNTV, SPACE_DATA
    } space_t;

    typedef enum logic [1:0] {KIND_COIL, KIND_INPUT, KIND_WORD} kind_t;

    typedef struct packed {
        logic        ok;
        space_t      sp;
        logic [10:0] idx;
    } map_t;

    function automatic logic [13:0] baud_div(input logic [2:0] sel);
        return 14'(CLK_HZ / (OVS * BAUD_RATE[sel]));
    endfunction

    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] r;
        r = crc ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic map_t addr_map(input kind_t k, input logic [15:0] a);
        map_t m;
        m = '{1'b0, SPACE_NONE, 11'h000};
        if (k == KIND_WORD) begin
            if (a < LIM_TMRV) m = '{1'b1, SPACE_TMRV, 11'(a)};
            else if (a >= BASE_CNTV && a < LIM_CNTV) m = '{1'b1, SPACE_CNTV, 11'(a - BASE_CNTV)};
            else if (a >= BASE_DATA && a < BASE_IO) m = '{1'b1, SPACE_DATA, 11'(a - BASE_DATA)};
        end else if (k == KIND_INPUT) begin
            if (a >= BASE_IO && a < BASE_RELAY) m = '{1'b1, SPACE_IN, 11'(a - BASE_IO)};
            else if (a >= BASE_RELAY && a < LIM_SYSREL) m = '{1'b1, SPACE_SYSREL, 11'(a - BASE_RELAY)};
        end else begin
            if (a >= BASE_IO && a < BASE_RELAY) m = '{1'b1, SPACE_OUT, 11'(a - BASE_IO)};
            else if (a >= BASE_RELAY && a < BASE_STAGE) m = '{1'b1, SPACE_CREL, 11'(a - BASE_RELAY)};
            else if (a >= BASE_STAGE && a < BASE_TMRC) m = '{1'b1, SPACE_STAGE, 11'(a - BASE_STAGE)};
            else if (a >= BASE_TMRC && a < BASE_CNTC) m = '{1'b1, SPACE_TMRC, 11'(a - BASE_TMRC)};
            else if (a >= BASE_CNTC && a < LIM_CNTC) m = '{1'b1, SPACE_CNTC, 11'(a - BASE_CNTC)};
        end
        return m;
    endfunction

endpackage

//--- core/baud_gen.sv
`timescale 1ns/1ps
module baud_gen (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [2:0] baud_sel,
    output logic            samp_tick
);
    import modbus_pkg::*;

    typedef struct packed {
        logic [13:0] cnt;
        logic        tick;
    } bg_t;

    bg_t c_r, c_nxt;

    always_comb begin
        c_nxt = c_r;
        c_nxt.tick = 1'b0;
        if (c_r.cnt == 14'h0000) begin
            c_nxt.cnt  = baud_div(baud_sel) - 14'h0001;
            c_nxt.tick = 1'b1;
        end else begin
            c_nxt.cnt = c_r.cnt - 14'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) c_r <= '0;
        else c_r <= c_nxt;
    end

    assign samp_tick = c_r.tick;

    tick_spacing_a: assert property (@(posedge clk) disable iff (!reset_n)
        samp_tick |=> !samp_tick [*8]) else $error("sample tick too close");

endmodule

//--- core/serial_rx.sv
`timescale 1ns/1ps
module serial_rx (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       samp_tick,
    input  wire logic       rx_pin,
    input  wire logic [1:0] parity_mode,
    input  wire logic       two_stop,
    output logic            byte_valid,
    output logic [7:0]      byte_data,
    output logic            byte_err
);
    import modbus_pkg::*;

    typedef enum logic [4:0] {
        RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
    } rx_st_t;

    typedef struct packed {
        rx_st_t     st;
        logic [1:0] sync;
        logic [3:0] ph;
        logic [2:0] n;
        logic [7:0] sh;
        logic       stop2;
        logic       err;
        logic       vld;
    } rx_t;

    rx_t c_r, c_nxt;
    logic line;

    assign line = c_r.sync[1];

    always_comb begin
        c_nxt = c_r;
        c_nxt.sync = {c_r.sync[0], rx_pin};
        c_nxt.vld  = 1'b0;
        if (samp_tick) begin
            c_nxt.ph = c_r.ph + 4'h1;
            case (c_r.st)
                RX_IDLE: begin
                    c_nxt.ph = 4'h0;
                    if (!line) c_nxt.st = RX_START;
                end
                RX_START: if (c_r.ph == 4'h7) begin
                    c_nxt.ph = 4'h0;
                    c_nxt.n  = 3'h0;
                    c_nxt.err = 1'b0;
                    c_nxt.stop2 = two_stop;
                    c_nxt.st = line ? RX_IDLE : RX_DATA;
                end
                RX_DATA: if (c_r.ph == 4'hf) begin
                    c_nxt.sh = {line, c_r.sh[7:1]};
                    c_nxt.n  = c_r.n + 3'h1;
                    if (c_r.n == 3'h7) c_nxt.st = (parity_mode == PAR_NONE) ? RX_STOP : RX_PAR;
                end
                RX_PAR: if (c_r.ph == 4'hf) begin
                    if (line != ((^c_r.sh) ^ (parity_mode == PAR_ODD))) c_nxt.err = 1'b1;
                    c_nxt.st = RX_STOP;
                end
                RX_STOP: if (c_r.ph == 4'hf) begin
                    if (!line) c_nxt.err = 1'b1;
                    c_nxt.stop2 = 1'b0;
                    if (!c_r.stop2) begin
                        c_nxt.vld = 1'b1;
                        c_nxt.st  = RX_IDLE;
                    end
                end
                default: c_nxt.st = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) c_r <= '{st: RX_IDLE, sync: 2'h3, default: '0};
        else c_r <= c_nxt;
    end

    assign byte_valid = c_r.vld;
    assign byte_data  = c_r.sh;
    assign byte_err   = c_r.vld & c_r.err;

    byte_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
        byte_valid |=> !byte_valid [*8]) else $error("received bytes too close");

endmodule

//--- tb/modbus_host_model.sv
`timescale 1ns/1ps
module modbus_host_model #(
    parameter int BIT_CLKS = 1296
) (
    input  wire logic clk,
    output logic      rx_pin
);
    initial rx_pin = 1'b1;

    task automatic put_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0}; // LSB first, one stop bit, no parity
        for (int i = 0; i < 10; i++) begin
            rx_pin <= f[i];
            repeat (BIT_CLKS) @(negedge clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Station, function, address, value, then check word low byte first
    task automatic send(input logic [7:0] p [$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (p[i]) begin
            c ^= {8'h00, p[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
            put_byte(p[i]);
        end
        put_byte(c[7:0]);
        put_byte(c[15:8]);
        // Idle high well past 3.5 characters so the frame closes
        repeat (BIT_CLKS * 45) @(negedge clk);
    endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import modbus_pkg::*;
    logic        clk, reset_n, rx_pin, master_busy, mem_req, mem_we, mem_wbit;
    logic        resp_valid, resp_done;
    space_t      mem_space;
    logic [10:0] mem_index, idx;
    logic [15:0] mem_wword, resp_data, rv;
    logic [15:0] mem_rdata = 16'h0000;
    logic [7:0]  resp_func, resp_exc;
    logic [31:0] q_mem [$];
    logic [15:0] q_rd [$], q_done [$];
    int          error_cnt, n_compared, seed;

    modbus_slave_decoder modbus_slave_decoder_inst (.clk(clk), .reset_n(reset_n),
        .rx_pin(rx_pin), .baud_sel(3'h7), .parity_mode(2'h0), .two_stop(1'b0),
        .station_addr(8'h11), .master_busy(master_busy), .mem_req(mem_req),
        .mem_we(mem_we), .mem_space(mem_space), .mem_index(mem_index),
        .mem_wbit(mem_wbit), .mem_wword(mem_wword), .mem_rdata(mem_rdata),
        .resp_valid(resp_valid), .resp_data(resp_data), .resp_done(resp_done),
        .resp_func(resp_func), .resp_exc(resp_exc));
    modbus_host_model modbus_host_model_inst (.clk(clk), .rx_pin(rx_pin));

    function automatic logic [15:0] rd_val(space_t s, logic [10:0] i);
        return (s >= SPACE_TMRV) ? {1'b0, s, i} : {15'h0000, i[0]};
    endfunction

    // Memory answers the cycle after a request, otherwise the bus keeps moving
    always_ff @(posedge clk) mem_rdata <= mem_req ? rd_val(mem_space, mem_index) : ~mem_rdata;

    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    always @(negedge clk) begin
        if (reset_n && mem_req === 1'b1)
            chk("mem", q_mem.size() ? q_mem.pop_front() : 'x, {mem_we, mem_space, mem_index,
                !mem_we ? 16'h0 : mem_space == SPACE_DATA ? mem_wword : {15'h0, mem_wbit}});
        if (reset_n && resp_valid === 1'b1)
            chk("rdata", q_rd.size() ? q_rd.pop_front() : 'x, resp_data);
        if (reset_n && resp_done === 1'b1)
            chk("done", q_done.size() ? q_done.pop_front() : 'x, {resp_func, resp_exc});
    end

    ////////////////////////////////////////////////////////////////////////////
    // Exception code ff marks a frame that must be dropped
    task automatic req(logic [7:0] fc, logic [15:0] a, logic [15:0] v, logic [7:0] exc,
                       space_t s, logic [10:0] i);
        logic [7:0] p [$];
        logic [7:0] b;
        p = {8'h11, fc, a[15:8], a[7:0], v[15:8], v[7:0]};
        // Group writes: byte count, then data bytes counting up from rv
        if (fc == FC_WR_COILS || fc == FC_WR_REGS) begin
            p.push_back(fc == FC_WR_REGS ? 8'(v * 2) : 8'((v + 7) / 8));
            for (int k = 0; k < p[6]; k++) p.push_back(8'(rv) + 8'(k));
        end
        if (exc == 8'h00 && (fc == FC_WR_COIL || fc == FC_WR_REG))
            q_mem.push_back({1'b1, s, i, fc == FC_WR_REG ? v : {15'h0, v[15]}});
        else if (exc == 8'h00 && (fc == FC_WR_COILS || fc == FC_WR_REGS))
            for (int k = 0; k < v; k++) begin
                b = 8'(rv) + 8'(k / 8);
                q_mem.push_back({1'b1, s, i + 11'(k), fc == FC_WR_COILS ? {15'h0, b[k % 8]}
                    : {8'(rv) + 8'(2 * k), 8'(rv) + 8'(2 * k + 1)}});
            end
        else if (exc == 8'h00)
            for (int k = 0; k < v; k++) begin
                q_mem.push_back({1'b0, s, i + 11'(k), 16'h0});
                q_rd.push_back(rd_val(s, i + 11'(k)));
            end
        if (exc != 8'hff) q_done.push_back({fc, exc});
        modbus_host_model_inst.send(p);
        for (int k = 0; k < 200 && q_done.size() != 0; k++) @(negedge clk);
        chk("pending", 32'h0, q_done.size() + q_mem.size() + q_rd.size());
    endtask

    task automatic conclude();
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        reset_n = 1'b0;
        master_busy = 1'b0;
        seed = 32'h448e;
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        req(FC_RD_COILS, 16'h18fe, 16'h0002, EXC_NONE, SPACE_TMRC, 11'h0fe);
        req(FC_RD_INPUTS, 16'h0dff, 16'h0001, EXC_NONE, SPACE_SYSREL, 11'h1ff);
        req(FC_RD_HOLD, 16'h0000, 16'h0001, EXC_NONE, SPACE_TMRV, 11'h000);
        req(FC_RD_INREG, 16'h02ff, 16'h0001, EXC_NONE, SPACE_CNTV, 11'h0ff);
        req(FC_WR_COIL, 16'h1900, COIL_ON, EXC_NONE, SPACE_CNTC, 11'h000);
        rv = 16'($random(seed));
        idx = {1'b0, rv[9:0]};
        req(FC_WR_REG, 16'h0400 + idx, rv, EXC_NONE, SPACE_DATA, idx);
        req(FC_WR_REGS, 16'h0410, 16'h0002, EXC_NONE, SPACE_DATA, 11'h010);
        req(FC_WR_COILS, 16'h0803, 16'h000a, EXC_NONE, SPACE_OUT, 11'h003);
        req(FC_WR_REG, 16'h00ff, rv, EXC_ILL_ADDR, SPACE_NONE, 11'h000);
        req(8'h07, 16'h0000, 16'h0001, EXC_ILL_FUNC, SPACE_NONE, 11'h000);
        master_busy = 1'b1;
        req(FC_WR_REG, 16'h0400, rv, 8'hff, SPACE_NONE, 11'h000);
        master_busy = 1'b0;
        req(FC_RD_HOLD, 16'h0400 + idx, 16'h0001, EXC_NONE, SPACE_DATA, idx);
        conclude();
    end
endmodule
